// ==== swc_wake_config.sv ====
/*
 * Selective-wake configuration registers behind an APB slave: calibration
 * enable and unlock key, time-out interrupt enable, configuration-valid
 * handshake, bit timing and upper wake identifier byte.
 * Assumes APB signals and device inputs are synchronous to pclk.
 */
// Function
// - Calibration mode bit 7 enables calibration
// - Key field 11 alone unlocks recalibration
// - Unlocked calibration uses transmit pin reference
// - Option register writable only when unlocked
// - Time-out enable bit gates interrupt pin
// - Time-out flag set only with selective wake
// - Selective wake enabled only while config valid
// - Config valid cleared on wake, reset, change
// - Reserved bits read as zero
// - Quanta per bit uses whole byte
// - Sample point is six-bit fraction
// - Identifier high byte bit 7 is 28
// - Standard identifier bits 28..21 compared
// - Restart keeps upper nibble, clears lower
// - Reset values A0 and 33, kept on restart
`include "swc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module swc_wake_config (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`SWC_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    soft_reset,
    input  wire logic                    restart_entry,
    input  wire logic                    wake_event,
    input  wire logic                    swk_transceiver_mode,
    input  wire logic                    bus_timeout,
    input  wire logic                    transmit_data_pin,
    input  wire logic [10:0]             std_id_rx,
    input  wire logic                    std_id_valid,
    output logic                         irq_n,
    output logic                         osc_cal_enable,
    output logic                         recal_unlocked,
    output logic                         cal_sync_ref,
    output logic                         swk_enable,
    output logic [7:0]                   quanta_per_bit,
    output logic [5:0]                   sample_point,
    output logic [7:0]                   low_power_receiver_option_reg,
    output logic                         id_match
);
    swc_pkg::swc_state_s state;
    swc_pkg::swc_state_s next_state;
    swc_pkg::swc_phase_e phase;
    swc_pkg::swc_phase_e next_phase;
    swc_if               mif ();
    logic                swk_en_q;
    logic                unlocked_q;
    logic                match_q;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Word-aligned register decode, low two address bits ignored
    function automatic logic hit(input logic [`SWC_ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a[`SWC_ADDR_W-1:2] == {idx[7:0]});
    endfunction

    // Key field holds the only unlocking pattern
    function automatic logic is_unlocked(input logic [7:0] c);
        is_unlocked = (c[`SWC_CTRL_KEY_HI:`SWC_CTRL_KEY_LO] == `SWC_KEY_UNLOCK);
    endfunction

    // Listed addresses answered without an error; decided with pready so pslverr stands with it
    function automatic logic known(input logic [`SWC_ADDR_W-1:0] a);
        known = hit(a, `SWC_IDX_CTRL) || hit(a, `SWC_IDX_QPB) || hit(a, `SWC_IDX_SPP)
                || hit(a, `SWC_IDX_IDH) || hit(a, `SWC_IDX_OPT)
                || hit(a, `SWC_IDX_STAT) || hit(a, `SWC_IDX_EVT);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Match front end

    swc_id_match u_match (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (mif)
    );

    assign mif.swk_enable        = state.ctrl[`SWC_CTRL_WAKE_CONFIG_VALID] && swk_transceiver_mode;
    assign mif.wake_id_high_byte = state.wake_id_high_byte;
    assign mif.std_id_rx         = std_id_rx;
    assign mif.std_id_valid      = std_id_valid;

    ////////////////////////////////////////////////////////////////////////////
    // Next state: APB access, config-valid handshake, time-out flag
    logic        wr_now;
    logic        rd_now;
    logic [7:0]  wbyte;
    logic [7:0]  rbyte;
    logic [7:0]  status;

    always_comb begin
        next_state = state;
        next_phase = phase;
        wr_now = 1'b0;
        rd_now = 1'b0;
        wbyte  = pwdata[7:0];
        rbyte  = 8'h00;
        status = 8'h00;
        next_state.pready = 1'b0;
        next_state.pslverr = 1'b0;

        // One wait state: setup, then access answered on the next edge
        unique case (phase)
            swc_pkg::SWC_PH_IDLE: begin
                if (psel && !penable) begin
                    next_phase = swc_pkg::SWC_PH_ACCESS;
                end
            end
            swc_pkg::SWC_PH_ACCESS: begin
                if (psel && penable && !state.pready) begin
                    next_state.pready = 1'b1;
                    next_state.pslverr = !known(paddr);
                    rd_now = !pwrite;
                end else if (state.pready) begin
                    // Write commits on the edge the master sees pready, never before
                    next_phase = swc_pkg::SWC_PH_IDLE;
                    wr_now = psel && penable && pwrite && pstrb[0];
                end
            end
        endcase

        status[`SWC_STAT_TO_FLAG] = state.bus_timeout_flag;
        status[`SWC_STAT_SWK_EN]  = mif.swk_enable;
        status[`SWC_STAT_CAL_ACT] = state.cal_ref;
        status[`SWC_STAT_UNLOCK]  = is_unlocked(state.ctrl);

        if (wr_now) begin
            if (hit(paddr, `SWC_IDX_CTRL)) begin
                // Reserved bits 3:1 never store; config valid written as given
                next_state.ctrl = wbyte & `SWC_CTRL_WR_MASK;
            end else if (hit(paddr, `SWC_IDX_QPB)) begin
                next_state.quanta_per_bit = wbyte;
                next_state.ctrl[`SWC_CTRL_WAKE_CONFIG_VALID] = 1'b0;
            end else if (hit(paddr, `SWC_IDX_SPP)) begin
                next_state.sample_point = wbyte & `SWC_SPP_MASK;
                next_state.ctrl[`SWC_CTRL_WAKE_CONFIG_VALID] = 1'b0;
            end else if (hit(paddr, `SWC_IDX_IDH)) begin
                next_state.wake_id_high_byte = wbyte;
                next_state.ctrl[`SWC_CTRL_WAKE_CONFIG_VALID] = 1'b0;
            end else if (hit(paddr, `SWC_IDX_OPT)) begin
                // Locked writes are dropped silently, bus still sees OKAY
                if (is_unlocked(state.ctrl)) begin
                    next_state.low_power_receiver_option_reg = wbyte;
                end
            end else if (hit(paddr, `SWC_IDX_EVT)) begin
                // Write one to clear; a time-out this cycle still wins below
                if (wbyte[`SWC_STAT_TO_FLAG]) begin
                    next_state.bus_timeout_flag = 1'b0;
                end
            end
        end

        if (rd_now) begin
            if (hit(paddr, `SWC_IDX_CTRL)) begin
                rbyte = state.ctrl & `SWC_CTRL_WR_MASK;
            end else if (hit(paddr, `SWC_IDX_QPB)) begin
                rbyte = state.quanta_per_bit;
            end else if (hit(paddr, `SWC_IDX_SPP)) begin
                rbyte = state.sample_point & `SWC_SPP_MASK;
            end else if (hit(paddr, `SWC_IDX_IDH)) begin
                rbyte = state.wake_id_high_byte;
            end else if (hit(paddr, `SWC_IDX_OPT)) begin
                rbyte = state.low_power_receiver_option_reg;
            end else if (hit(paddr, `SWC_IDX_STAT) || hit(paddr, `SWC_IDX_EVT)) begin
                rbyte = status;
            end
            next_state.prdata = {24'h00_0000, rbyte};
        end

        // Time-out is only recorded with selective wake transceiver mode
        if (bus_timeout && swk_transceiver_mode) begin
            next_state.bus_timeout_flag = 1'b1;
        end

        // Any wake ends the validated configuration
        if (wake_event) begin
            next_state.ctrl[`SWC_CTRL_WAKE_CONFIG_VALID] = 1'b0;
        end

        // Restart keeps upper nibble and bit timing, clears lower nibble
        if (restart_entry) begin
            next_state.ctrl = state.ctrl & `SWC_CTRL_KEEP_MASK;
        end

        // Soft reset returns every configuration register and the time-out flag to power-on values
        if (soft_reset) begin
            next_state.ctrl = `SWC_CTRL_RST;
            next_state.quanta_per_bit = `SWC_QPB_RST;
            next_state.sample_point = `SWC_SPP_RST;
            next_state.wake_id_high_byte = `SWC_IDH_RST;
            next_state.low_power_receiver_option_reg = `SWC_OPT_RST;
            next_state.bus_timeout_flag = 1'b0;
        end

        // Interrupt pin reflects the flag only while enabled
        next_state.irq = next_state.bus_timeout_flag && next_state.ctrl[`SWC_CTRL_TO_IE];

        // Trim reference taken from transmit pin only while unlocked
        next_state.cal_ref = next_state.ctrl[`SWC_CTRL_OSC_CAL] && is_unlocked(next_state.ctrl)
                             && transmit_data_pin;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
            state.quanta_per_bit <= `SWC_QPB_RST;
            state.sample_point <= `SWC_SPP_RST;
            phase <= swc_pkg::SWC_PH_IDLE;
            swk_en_q <= 1'b0;
            unlocked_q <= 1'b0;
            match_q <= 1'b0;
        end else begin
            state <= next_state;
            phase <= next_phase;
            swk_en_q <= mif.swk_enable;
            unlocked_q <= is_unlocked(next_state.ctrl);
            match_q <= mif.id_match;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    assign prdata         = state.prdata;
    assign pready         = state.pready;
    assign pslverr        = state.pslverr;
    assign irq_n          = !state.irq;
    assign osc_cal_enable = state.ctrl[`SWC_CTRL_OSC_CAL];
    assign recal_unlocked = unlocked_q;
    assign cal_sync_ref   = state.cal_ref;
    assign swk_enable     = swk_en_q;
    assign quanta_per_bit = state.quanta_per_bit;
    assign sample_point   = state.sample_point[5:0];
    assign low_power_receiver_option_reg = state.low_power_receiver_option_reg;
    assign id_match       = match_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // A completed write: the edge at which the master sees pready
    sequence s_commit;
        psel && penable && pready && pwrite && pstrb[0];
    endsequence

    sequence s_read;
        psel && penable && pready && !pwrite;
    endsequence

    sequence s_locked_opt_write;
        s_commit ##0 hit(paddr, `SWC_IDX_OPT) && !unlocked_q && !soft_reset;
    endsequence

    chk_opt_write_lock: assert property (@(posedge pclk) disable iff (!presetn)
        s_locked_opt_write |=> $stable(low_power_receiver_option_reg))
        else $error("option register changed while locked");

    chk_opt_write_open: assert property (@(posedge pclk) disable iff (!presetn)
        s_commit ##0 hit(paddr, `SWC_IDX_OPT) && unlocked_q && !soft_reset
        |=> low_power_receiver_option_reg == $past(pwdata[7:0]))
        else $error("option register write lost while unlocked");

    chk_unlock_needs_key: assert property (@(posedge pclk) disable iff (!presetn)
        recal_unlocked |-> state.ctrl[`SWC_CTRL_KEY_HI:`SWC_CTRL_KEY_LO] == `SWC_KEY_UNLOCK)
        else $error("recalibration unlocked without key");

    chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !state.ctrl[`SWC_CTRL_TO_IE] |-> irq_n)
        else $error("interrupt while time-out enable clear");

    chk_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
        state.bus_timeout_flag && state.ctrl[`SWC_CTRL_TO_IE] |-> !irq_n)
        else $error("enabled time-out not signalled");

    chk_flag_needs_mode: assert property (@(posedge pclk) disable iff (!presetn)
        !state.bus_timeout_flag && !swk_transceiver_mode |=> !state.bus_timeout_flag)
        else $error("time-out flag set outside selective wake mode");

    chk_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        bus_timeout && swk_transceiver_mode && !soft_reset |=> state.bus_timeout_flag)
        else $error("time-out lost");

    chk_swk_needs_valid: assert property (@(posedge pclk) disable iff (!presetn)
        swk_enable |-> $past(state.ctrl[`SWC_CTRL_WAKE_CONFIG_VALID]))
        else $error("selective wake enabled without valid configuration");

    chk_wake_clears_valid: assert property (@(posedge pclk) disable iff (!presetn)
        wake_event |=> !state.ctrl[`SWC_CTRL_WAKE_CONFIG_VALID])
        else $error("config valid survived wake");

    chk_change_clears_valid: assert property (@(posedge pclk) disable iff (!presetn)
        s_commit ##0 (hit(paddr, `SWC_IDX_QPB) || hit(paddr, `SWC_IDX_SPP) || hit(paddr, `SWC_IDX_IDH))
        |=> !state.ctrl[`SWC_CTRL_WAKE_CONFIG_VALID])
        else $error("config valid survived a configuration change");

    chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        state.ctrl[3:1] == 3'h0 && state.sample_point[7:6] == 2'h0)
        else $error("reserved bits hold ones");

    chk_read_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        s_read |-> prdata[31:8] == 24'h00_0000
        && !(hit(paddr, `SWC_IDX_CTRL) && prdata[3:1] != 3'h0)
        && !(hit(paddr, `SWC_IDX_SPP) && prdata[7:6] != 2'h0))
        else $error("reserved bits read as ones");

    chk_quanta_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_commit ##0 hit(paddr, `SWC_IDX_QPB) && !soft_reset |=> quanta_per_bit == $past(pwdata[7:0]))
        else $error("quanta per bit write lost");

    chk_sample_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_commit ##0 hit(paddr, `SWC_IDX_SPP) && !soft_reset |=> sample_point == $past(pwdata[5:0]))
        else $error("sample point write lost");

    chk_id_byte_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_commit ##0 hit(paddr, `SWC_IDX_IDH) && !soft_reset
        |=> state.wake_id_high_byte == $past(pwdata[7:0]))
        else $error("identifier byte write lost");

    chk_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_commit ##0 hit(paddr, `SWC_IDX_CTRL) && !wake_event && !restart_entry && !soft_reset
        |=> state.ctrl == ($past(pwdata[7:0]) & `SWC_CTRL_WR_MASK))
        else $error("control write stored reserved bits or was lost");

    chk_restart_keep: assert property (@(posedge pclk) disable iff (!presetn)
        restart_entry && !soft_reset |=> state.ctrl[3:0] == 4'h0
        && state.ctrl[7:4] == $past(state.ctrl[7:4]) && $stable(quanta_per_bit))
        else $error("restart handled wrongly");

    chk_soft_reset_vals: assert property (@(posedge pclk) disable iff (!presetn)
        soft_reset |=> quanta_per_bit == `SWC_QPB_RST && state.sample_point == `SWC_SPP_RST
        && state.ctrl == `SWC_CTRL_RST)
        else $error("soft reset values wrong");

    chk_cal_ref_lock: assert property (@(posedge pclk) disable iff (!presetn)
        cal_sync_ref |-> osc_cal_enable && recal_unlocked)
        else $error("trim reference used while locked");
endmodule // swc_wake_config
`default_nettype wire

// ==== swc_regs.svh ====
/*
 * Register offsets, field positions, masks, reset values and status bits of the
 * selective-wake configuration slice. Assumes inclusion by bare name.
 */
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH

// Register indices; the bus byte address is four times the index
`define SWC_IDX_CTRL        8'h20
`define SWC_IDX_QPB         8'h21
`define SWC_IDX_SPP         8'h22
`define SWC_IDX_IDH         8'h23
`define SWC_IDX_OPT         8'h30
`define SWC_IDX_STAT        8'h31
`define SWC_IDX_EVT         8'h32
`define SWC_ADDR_W          10

// Control register fields
`define SWC_CTRL_OSC_CAL    7
`define SWC_CTRL_KEY_HI     6
`define SWC_CTRL_KEY_LO     5
`define SWC_CTRL_TO_IE      4
`define SWC_CTRL_WAKE_CONFIG_VALID    0
`define SWC_KEY_UNLOCK      2'h3
`define SWC_CTRL_WR_MASK    8'hf1
`define SWC_CTRL_KEEP_MASK  8'hf0
`define SWC_SPP_MASK        8'h3f

// Reset values
`define SWC_CTRL_RST        8'h00
`define SWC_QPB_RST         8'ha0
`define SWC_SPP_RST         8'h33
`define SWC_IDH_RST         8'h00
`define SWC_OPT_RST         8'h00

// Status bits in the status register
`define SWC_STAT_TO_FLAG    0
`define SWC_STAT_SWK_EN     1
`define SWC_STAT_CAL_ACT    2
`define SWC_STAT_UNLOCK     3

`endif

// ==== swc_pkg.sv ====
/*
 * Types of the selective-wake configuration slice.
 * Assumes swc_regs.svh constants are used alongside.
 */
package swc_pkg;
    typedef enum logic [1:0] {
        SWC_PH_IDLE,
        SWC_PH_ACCESS
    } swc_phase_e;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] quanta_per_bit;
        logic [7:0] sample_point;
        logic [7:0] wake_id_high_byte;
        logic [7:0] low_power_receiver_option_reg;
        logic       bus_timeout_flag;
        logic       irq;
        logic       cal_ref;
        logic       pready;
        logic [31:0] prdata;
        logic       pslverr;
    } swc_state_s;
endpackage : swc_pkg

// ==== swc_if.sv ====
/*
 * Interface between the register file and the match front end.
 * Assumes both ends run on pclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface swc_if;
    logic        swk_enable;
    logic [7:0]  wake_id_high_byte;
    logic [10:0] std_id_rx;
    logic        std_id_valid;
    logic        id_match;

    modport regs (output swk_enable, output wake_id_high_byte, input id_match);
    modport match (input swk_enable, input wake_id_high_byte, input std_id_rx,
                   input std_id_valid, output id_match);
endinterface : swc_if
`default_nettype wire

// ==== swc_id_match.sv ====
/*
 * Compares the upper byte of a received standard identifier with the stored
 * wake identifier byte. Assumes identifiers arrive synchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module swc_id_match (
    input  wire logic pclk,
    input  wire logic presetn,
    swc_if.match      bus
);
    typedef struct packed {
        logic hit;
    } swc_match_s;

    swc_match_s state;
    swc_match_s next_state;

    ////////////////////////////////////////////////////////////////////////////
    // Standard id sits in bits 28..18, so its top eight bits meet byte 28..21
    always_comb begin
        next_state = state;
        if (bus.std_id_valid) begin
            next_state.hit = bus.swk_enable && (bus.std_id_rx[10:3] == bus.wake_id_high_byte);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign bus.id_match = state.hit;

    chk_match_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
        bus.std_id_valid && !bus.swk_enable |=> !bus.id_match)
        else $error("id match while selective wake disabled");
endmodule // swc_id_match
`default_nettype wire

// ==== swc_can_node.sv ====
/*
 * Behavioural CAN node that hands received standard identifiers and bus
 * time-outs to the wake slice. Assumes requests arrive just after pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module swc_can_node (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        go,
    input  wire logic [10:0] id_in,
    input  wire logic        to_go,
    output logic      [10:0] std_id_rx,
    output logic             std_id_valid,
    output logic             bus_timeout
);
    // Identifier bit 10 carries id28; outside a frame the lines toggle so stale data never matches by luck
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            std_id_rx    <= 11'h000;
            std_id_valid <= 1'b0;
            bus_timeout  <= 1'b0;
        end else begin
            std_id_valid <= go;
            bus_timeout  <= to_go;
            std_id_rx    <= go ? id_in : ~std_id_rx;
        end
    end
endmodule // swc_can_node
`default_nettype wire

// ==== swc_wake_config_test.sv ====
/*
 * Self-checking bench of the wake configuration slice over APB.
 * Assumes swc_regs.svh and the CAN node model are compiled alongside.
 */
`include "swc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module swc_wake_config_test;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [9:0]  paddr = 0;
    logic [31:0] pwdata = 0, seed = 32'hf9f2_af48, q, d;
    logic [3:0]  pstrb = 4'hf;
    logic        soft_reset = 0, restart_entry = 0, wake_event = 0, mode = 0, tx_pin = 0;
    logic        go = 0, to_go = 0, e, m;
    logic [10:0] id_in = 0;
    wire  [31:0] prdata;
    wire  [10:0] std_id_rx;
    wire  [7:0]  qpb, opt;
    wire  [5:0]  sp;
    wire         pready, pslverr, irq_n, osc, unl, cref, swk_en, id_match, std_id_valid, bus_timeout;
    int          n_fail = 0, checks_done = 0;
    localparam logic [9:0] A_CTRL = {`SWC_IDX_CTRL, 2'b00}, A_QPB = {`SWC_IDX_QPB, 2'b00};
    localparam logic [9:0] A_SPP = {`SWC_IDX_SPP, 2'b00}, A_IDH = {`SWC_IDX_IDH, 2'b00};
    localparam logic [9:0] A_OPT = {`SWC_IDX_OPT, 2'b00}, A_STAT = {`SWC_IDX_STAT, 2'b00};
    localparam logic [9:0] A_EVT = {`SWC_IDX_EVT, 2'b00};

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, reset and design instances
    always #5 pclk = ~pclk;
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
    end
    swc_wake_config i_swc_wake_config (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .soft_reset(soft_reset), .restart_entry(restart_entry), .wake_event(wake_event),
        .swk_transceiver_mode(mode), .bus_timeout(bus_timeout), .transmit_data_pin(tx_pin),
        .std_id_rx(std_id_rx), .std_id_valid(std_id_valid), .irq_n(irq_n), .osc_cal_enable(osc),
        .recal_unlocked(unl), .cal_sync_ref(cref), .swk_enable(swk_en), .quanta_per_bit(qpb),
        .sample_point(sp), .low_power_receiver_option_reg(opt), .id_match(id_match));
    swc_can_node i_swc_can_node (.pclk(pclk), .presetn(presetn), .go(go), .id_in(id_in), .to_go(to_go),
        .std_id_rx(std_id_rx), .std_id_valid(std_id_valid), .bus_timeout(bus_timeout));

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers: random source, expectations, comparison and bus cycles
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Reserved control bits always read back as zero
    function automatic logic [7:0] f_ctrl(input logic [7:0] v);
        return v & 8'hf1;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits a clock first so release and next setup never share an edge
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk(32'h0, 32'h1);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Single-cycle pulse on one of the event inputs
    task automatic pulse(input int k);
        @(posedge pclk);
        case (k)
            0: wake_event <= 1'b1;
            1: restart_entry <= 1'b1;
            2: soft_reset <= 1'b1;
            default: to_go <= 1'b1;
        endcase
        @(posedge pclk);
        {wake_event, restart_entry, soft_reset, to_go} <= 4'h0;
        tick(2);
    endtask
    // Frame from the CAN node; a match is searched over a short window
    task automatic send(input logic [10:0] id);
        @(posedge pclk);
        id_in <= id;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        // The previous hit stands until this frame's result reaches the pin two edges later
        repeat (2) @(posedge pclk);
        m = 1'b0;
        repeat (3) begin
            @(posedge pclk);
            m = m | (id_match === 1'b1);
        end
    endtask
    task automatic stop_test();
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole sequence needs about 500 cycles
    initial begin
        #200us;
        n_fail++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        @(posedge presetn);
        apb(0, A_CTRL, 0); chk(q, 32'h00);
        apb(0, A_QPB, 0); chk(q, 32'ha0);
        apb(0, A_SPP, 0); chk(q, 32'h33);
        apb(0, 10'h3fc, 0); chk(e, 1);
        // Random bit timing and identifier bytes, reserved bits written as ones
        repeat (6) begin
            d = xs() | 32'hc0;
            apb(1, A_QPB, d); apb(0, A_QPB, 0); chk(q, d[7:0]);
            apb(1, A_SPP, d); apb(0, A_SPP, 0); chk(q, d[5:0]);
            apb(1, A_IDH, d); apb(0, A_IDH, 0); chk(q, d[7:0]);
            tick(2); chk(qpb, d[7:0]); chk(sp, d[5:0]);
        end
        // Every key value with random companions
        for (int k = 0; k < 4; k++) begin
            d = (xs() & 32'h9e) | (k << 5);
            apb(1, A_CTRL, d); apb(0, A_CTRL, 0); chk(q, f_ctrl(d[7:0]));
            tick(2); chk(osc, d[7]); chk(unl, k == 3);
        end
        apb(1, A_CTRL, 8'he0);
        for (int t = 0; t < 2; t++) begin
            @(posedge pclk) tx_pin <= t[0];
            tick(3); chk(cref, t[0]);
        end
        apb(1, A_CTRL, 8'h60); tick(3); chk(cref, 0);
        apb(1, A_OPT, 8'ha5); apb(0, A_OPT, 0); chk(q, 8'ha5); chk(opt, 8'ha5);
        apb(1, A_CTRL, 8'h00); apb(1, A_OPT, 8'h5a); apb(0, A_OPT, 0); chk(q, 8'ha5);
        // Configuration-valid handshake and its automatic clearing
        mode <= 1'b1;
        apb(1, A_CTRL, 8'h91); tick(3); chk(swk_en, 1);
        d = xs();
        apb(1, A_QPB, d); apb(0, A_CTRL, 0); chk(q, 8'h90); tick(2); chk(swk_en, 0);
        apb(1, A_CTRL, 8'h91); pulse(0); apb(0, A_CTRL, 0); chk(q, 8'h90);
        apb(1, A_CTRL, 8'hf1); pulse(1); apb(0, A_CTRL, 0); chk(q, 8'hf0);
        apb(0, A_QPB, 0); chk(q, d[7:0]);
        // Time-out flag only with selective wake mode, interrupt only when enabled
        mode <= 1'b0;
        apb(1, A_CTRL, 8'h10); pulse(3); apb(0, A_STAT, 0); chk(q[0], 0); chk(irq_n, 1);
        mode <= 1'b1;
        apb(1, A_CTRL, 8'h00); pulse(3); apb(0, A_STAT, 0); chk(q[0], 1); chk(irq_n, 1);
        apb(1, A_CTRL, 8'h10); tick(3); chk(irq_n, 0);
        apb(1, A_EVT, 1); tick(3); chk(irq_n, 1);
        // Wake identifier match on the upper byte of a standard identifier
        repeat (4) begin
            d = xs();
            apb(1, A_IDH, d); apb(1, A_CTRL, 8'h01); tick(3);
            send({d[7:0], d[10:8]}); chk(m, 1);
            send({~d[7:0], d[10:8]}); chk(m, 0);
            apb(1, A_CTRL, 8'h00); tick(3);
            send({d[7:0], d[10:8]}); chk(m, 0);
        end
        // Soft reset brings back the power-on values
        pulse(2);
        apb(0, A_QPB, 0); chk(q, 32'ha0);
        apb(0, A_SPP, 0); chk(q, 32'h33);
        apb(0, A_CTRL, 0); chk(q, 32'h00);
        stop_test();
    end
endmodule // swc_wake_config_test
`default_nettype wire
